// >>> rtl/clock_gating_map.svh
`ifndef CLOCK_GATING_MAP_SVH
`define CLOCK_GATING_MAP_SVH

// Gated clock outputs, index into the gate cell array
`define CLK_SYS 0
`define CLK_CORE 1
`define CLK_PG 2
`define CLK_PU 3
`define CLK_CAN 4
`define CLK_OUT 5
`define NUM_GATED 6

// Oscillator inputs, index into the synchroniser vector
`define SRC_MAIN 0
`define SRC_SUB 1
`define SRC_LSI 2
`define SRC_HSI 3
`define SRC_PLL 4
`define NUM_SRC 5

`define MCLK_PERIOD_NS 5
`define CNT_W 12
`define HSI_STAB_NS 2000
`define HSI_STAB_CYC ((`HSI_STAB_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define PLL_LOCK_NS 1000
`define PLL_LOCK_CYC ((`PLL_LOCK_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define MON_TIMEOUT_NS 5000
`define MON_TIMEOUT_CYC (`MON_TIMEOUT_NS / `MCLK_PERIOD_NS)

`endif

// >>> rtl/clock_gating_pkg.sv
package clock_gating_pkg;

  typedef enum logic [3:0] {
    st_stab, st_run, st_halt, st_light_idle_mode, st_deep_idle_mode, st_stop, st_sub,
    st_subidle, st_settle
  } pm_state_t;

  typedef enum logic [2:0] {
    req_run, req_light_idle_mode, req_deep_idle_mode, req_stop, req_sub, req_subidle
  } mode_req_t;

  typedef struct packed {
    logic wr;
    mode_req_t code;
  } mode_cmd_t;

  typedef struct packed {
    logic main;
    logic hsi;
    logic lsi;
    logic pll;
    logic flash;
  } osc_en_t;

endpackage : clock_gating_pkg

// >>> rtl/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 5
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = srst ? '0 : async_in;
    sync_nxt = srst ? '0 : meta_r;
  end

  always_ff @(posedge mclk) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign sync_out = sync_r;
endmodule : level_sync

// >>> rtl/clock_gate_cell.sv
`timescale 1ns/1ps
module clock_gate_cell (
  input wire logic mclk,
  input wire logic srst,
  input wire logic src,
  input wire logic en,
  output logic gclk
);
  logic en_r;
  logic en_nxt;
  logic gclk_r;
  logic gclk_nxt;

  // Enable may only move while the source is low
  always_comb begin
    en_nxt = en_r;
    if (srst) begin
      en_nxt = 1'b0;
    end else if (!src) begin
      en_nxt = en;
    end
    gclk_nxt = srst ? 1'b0 : (src & en_r);
  end

  always_ff @(posedge mclk) begin
    en_r <= en_nxt;
    gclk_r <= gclk_nxt;
  end

  assign gclk = gclk_r;

  a_gate_low_change: assert property (@(posedge mclk) disable iff (srst)
    $changed(en_r) |-> !$past(src))
    else $error("gate enable changed while source high");
endmodule : clock_gate_cell

// >>> rtl/clock_gating_power_modes.sv
`timescale 1ns/1ps
`include "clock_gating_map.svh"
module clock_gating_power_modes (
  input wire logic mclk,
  input wire logic srst,
  input wire logic main_osc_clock,
  input wire logic sub_osc_clock,
  input wire logic low_speed_internal_clock,
  input wire logic high_speed_internal_clock,
  input wire logic pll_clock,
  input wire logic halt_exec,
  input wire clock_gating_pkg::mode_cmd_t mode_cmd,
  input wire logic wake,
  input wire logic main_sel,
  input wire logic pll_sel,
  input wire logic subclock_source_select,
  input wire logic system_clock_out_en,
  input wire logic clk_mon_en,
  output logic cpu_run,
  output clock_gating_pkg::pm_state_t mode_state,
  output clock_gating_pkg::osc_en_t osc_en,
  output logic cpu_system_clock,
  output logic cpu_core_clock,
  output logic peripheral_clock_gated,
  output logic peripheral_clock_ungated,
  output logic can_osc_clock,
  output logic system_clock_out,
  output logic system_clock_out_oe,
  output logic supervision_reset
);
  localparam logic [`CNT_W-1:0] HSI_LIM = `CNT_W'(`HSI_STAB_CYC - 1);
  localparam logic [`CNT_W-1:0] PLL_LIM = `CNT_W'(`PLL_LOCK_CYC - 1);
  localparam logic [`CNT_W-1:0] MON_LIM = `CNT_W'(`MON_TIMEOUT_CYC - 1);
  // Gate enables per power state
  function automatic logic [`NUM_GATED-1:0] clk_en(
    input clock_gating_pkg::pm_state_t s, input logic out_en);
    logic [`NUM_GATED-1:0] e;
    e = '0;
    case (s)
      clock_gating_pkg::st_run, clock_gating_pkg::st_sub: begin
        e = '1;
      end
      clock_gating_pkg::st_halt: begin
        e = '1;
        e[`CLK_CORE] = 1'b0;
      end
      clock_gating_pkg::st_light_idle_mode, clock_gating_pkg::st_subidle: begin
        e[`CLK_PU] = 1'b1;
      end
      default: begin
        e = '0;
      end
    endcase
    e[`CLK_OUT] = e[`CLK_SYS] & out_en;
    return e;
  endfunction : clk_en
  // Oscillator enables per power state
  function automatic clock_gating_pkg::osc_en_t osc_of(
    input clock_gating_pkg::pm_state_t s, input logic use_pll);
    clock_gating_pkg::osc_en_t o;
    o = '{main: 1'b1, hsi: 1'b1, lsi: 1'b1, pll: use_pll, flash: 1'b1};
    case (s)
      clock_gating_pkg::st_stab: begin
        o = '{main: 1'b0, hsi: 1'b1, lsi: 1'b1, pll: 1'b0, flash: 1'b1};
      end
      clock_gating_pkg::st_deep_idle_mode: begin
        o.pll = 1'b0;
        o.flash = 1'b0;
      end
      clock_gating_pkg::st_stop: begin
        o = '0;
      end
      default: begin
        o.pll = use_pll;
      end
    endcase
    return o;
  endfunction : osc_of

  logic [`NUM_SRC-1:0] lvl;
  logic [`NUM_GATED-1:0] src, en, gclk;
  logic main_lvl, sub_lvl, on_sub;
  clock_gating_pkg::pm_state_t state_r, state_nxt;
  logic [`CNT_W-1:0] cnt_r, cnt_nxt;
  logic strap_r, strap_nxt;
  logic cpu_run_r, cpu_run_nxt;
  clock_gating_pkg::osc_en_t osc_r, osc_nxt;
  logic oe_r, oe_nxt;
  logic main_d_r, main_d_nxt;
  logic [`CNT_W-1:0] mon_cnt_r, mon_cnt_nxt;
  logic sup_r, sup_nxt;
  logic mon_active;

  level_sync #(.W(`NUM_SRC)) u_sync (
    .mclk(mclk),
    .srst(srst),
    .async_in({pll_clock, high_speed_internal_clock,
               low_speed_internal_clock, sub_osc_clock, main_osc_clock}),
    .sync_out(lvl)
  );
  // Source selection feeding the gate cells
  always_comb begin
    on_sub = (state_r == clock_gating_pkg::st_sub) ||
             (state_r == clock_gating_pkg::st_subidle);
    sub_lvl = strap_r ? lvl[`SRC_LSI] : lvl[`SRC_SUB];
    main_lvl = !main_sel ? lvl[`SRC_HSI] :
               (pll_sel ? lvl[`SRC_PLL] : lvl[`SRC_MAIN]);
    src[`CLK_SYS] = on_sub ? sub_lvl : main_lvl;
    src[`CLK_CORE] = src[`CLK_SYS];
    src[`CLK_PG] = main_lvl;
    src[`CLK_PU] = main_lvl;
    src[`CLK_CAN] = lvl[`SRC_MAIN];
    src[`CLK_OUT] = src[`CLK_SYS];
    en = clk_en(state_r, system_clock_out_en);
  end
  generate
    for (genvar k = 0; k < `NUM_GATED; k++) begin : g_gate
      clock_gate_cell u_gate (
        .mclk(mclk),
        .srst(srst),
        .src(src[k]),
        .en(en[k]),
        .gclk(gclk[k])
      );
    end
  endgenerate
  // Power mode sequencing
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    strap_nxt = strap_r;
    if (srst) begin
      state_nxt = clock_gating_pkg::st_stab;
      cnt_nxt = '0;
      strap_nxt = 1'b0;
    end else begin
      case (state_r)
        clock_gating_pkg::st_stab: begin
          strap_nxt = subclock_source_select;
          cnt_nxt = cnt_r + `CNT_W'(1);
          if (cnt_r == HSI_LIM) begin
            state_nxt = clock_gating_pkg::st_run;
            cnt_nxt = '0;
          end
        end
        clock_gating_pkg::st_settle: begin
          cnt_nxt = cnt_r + `CNT_W'(1);
          if (cnt_r == PLL_LIM) begin
            state_nxt = clock_gating_pkg::st_run;
            cnt_nxt = '0;
          end
        end
        clock_gating_pkg::st_run: begin
          if (halt_exec) begin
            state_nxt = clock_gating_pkg::st_halt;
          end else if (mode_cmd.wr) begin
            case (mode_cmd.code)
              clock_gating_pkg::req_light_idle_mode: begin
                state_nxt = clock_gating_pkg::st_light_idle_mode;
              end
              clock_gating_pkg::req_deep_idle_mode: begin
                state_nxt = clock_gating_pkg::st_deep_idle_mode;
              end
              clock_gating_pkg::req_stop: begin
                state_nxt = clock_gating_pkg::st_stop;
              end
              clock_gating_pkg::req_sub: begin
                state_nxt = clock_gating_pkg::st_sub;
              end
              default: begin
                state_nxt = state_r;
              end
            endcase
          end
        end
        clock_gating_pkg::st_sub: begin
          if (mode_cmd.wr &&
              mode_cmd.code == clock_gating_pkg::req_subidle) begin
            state_nxt = clock_gating_pkg::st_subidle;
          end else if (mode_cmd.wr &&
                       mode_cmd.code == clock_gating_pkg::req_run) begin
            state_nxt = clock_gating_pkg::st_run;
          end
        end
        clock_gating_pkg::st_halt, clock_gating_pkg::st_light_idle_mode: begin
          if (wake) begin
            state_nxt = clock_gating_pkg::st_run;
          end
        end
        clock_gating_pkg::st_subidle: begin
          if (wake) begin
            state_nxt = clock_gating_pkg::st_sub;
          end
        end
        clock_gating_pkg::st_deep_idle_mode: begin
          if (wake) begin
            state_nxt = clock_gating_pkg::st_settle;
          end
        end
        clock_gating_pkg::st_stop: begin
          if (wake) begin
            state_nxt = clock_gating_pkg::st_stab;
            cnt_nxt = '0;
          end
        end
        default: begin
          state_nxt = clock_gating_pkg::st_stab;
          cnt_nxt = '0;
        end
      endcase
    end
    cpu_run_nxt = !srst && ((state_nxt == clock_gating_pkg::st_run) ||
                            (state_nxt == clock_gating_pkg::st_sub));
    osc_nxt = srst ? '0 : osc_of(state_nxt, main_sel & pll_sel);
    oe_nxt = !srst && (state_nxt != clock_gating_pkg::st_stab) && system_clock_out_en;
  end
  always_ff @(posedge mclk) begin
    state_r <= state_nxt;
    cnt_r <= cnt_nxt;
    strap_r <= strap_nxt;
    cpu_run_r <= cpu_run_nxt;
    osc_r <= osc_nxt;
    oe_r <= oe_nxt;
  end
  // Main oscillator supervision, edge timeout
  always_comb begin
    mon_active = clk_mon_en && osc_r.lsi && osc_r.main && !srst;
    main_d_nxt = srst ? 1'b0 : lvl[`SRC_MAIN];
    mon_cnt_nxt = '0;
    sup_nxt = 1'b0;
    if (mon_active && !(lvl[`SRC_MAIN] ^ main_d_r)) begin
      mon_cnt_nxt = (mon_cnt_r == MON_LIM) ? '0 : mon_cnt_r + `CNT_W'(1);
      sup_nxt = (mon_cnt_r == MON_LIM);
    end
  end
  always_ff @(posedge mclk) begin
    main_d_r <= main_d_nxt;
    mon_cnt_r <= mon_cnt_nxt;
    sup_r <= sup_nxt;
  end
  assign cpu_run = cpu_run_r;
  assign mode_state = state_r;
  assign osc_en = osc_r;
  assign cpu_system_clock = gclk[`CLK_SYS];
  assign cpu_core_clock = gclk[`CLK_CORE];
  assign peripheral_clock_gated = gclk[`CLK_PG];
  assign peripheral_clock_ungated = gclk[`CLK_PU];
  assign can_osc_clock = gclk[`CLK_CAN];
  assign system_clock_out = gclk[`CLK_OUT];
  assign system_clock_out_oe = oe_r;
  assign supervision_reset = sup_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // A gate may close late while its source is high, so no new pulse starts
  a_core_halt_off: assert property (
    (state_r == clock_gating_pkg::st_halt)[*3] |-> !$rose(cpu_core_clock))
    else $error("core clock running in halt");
  a_gated_light_idle_mode: assert property (
    (state_r == clock_gating_pkg::st_light_idle_mode)[*3] |-> !$rose(gclk[`CLK_PG]))
    else $error("gated peripheral clock running in light idle");
  a_ungated_light_idle_mode: assert property (
    (state_r == clock_gating_pkg::st_light_idle_mode)[*3] ##0 $rose(main_lvl)
    |=> peripheral_clock_ungated)
    else $error("ungated peripheral clock stopped in light idle");
  a_can_idle_off: assert property (
    (state_r inside {clock_gating_pkg::st_light_idle_mode,
                     clock_gating_pkg::st_deep_idle_mode})[*3]
    |-> !$rose(can_osc_clock))
    else $error("CAN clock running in idle");
  a_mon_timeout: assert property (
    mon_active && mon_cnt_r == MON_LIM && !(lvl[`SRC_MAIN] ^ main_d_r)
    |=> supervision_reset)
    else $error("no supervision reset after timeout");
  a_mon_lsi: assert property (
    supervision_reset |-> $past(osc_r.lsi) && $past(clk_mon_en))
    else $error("supervision reset without low-speed oscillator");
  a_halt_entry: assert property (
    state_r == clock_gating_pkg::st_halt &&
    $past(state_r) != clock_gating_pkg::st_halt |-> $past(halt_exec))
    else $error("halt entered without instruction");
  a_halt_wake: assert property (
    state_r == clock_gating_pkg::st_halt && wake
    |=> state_r == clock_gating_pkg::st_run && cpu_run)
    else $error("halt release not immediate");
  a_light_idle_mode_pll: assert property (
    state_r == clock_gating_pkg::st_light_idle_mode && $stable(pll_sel) &&
    $stable(main_sel) |=> osc_r.pll == $past(osc_r.pll) && osc_r.main)
    else $error("PLL state lost in light idle");
  a_deep_idle_mode_pll: assert property (
    state_r == clock_gating_pkg::st_deep_idle_mode |-> !osc_r.pll && osc_r.main)
    else $error("PLL running in deep idle");
  a_stop_osc: assert property (
    state_r == clock_gating_pkg::st_stop |-> osc_r == '0)
    else $error("oscillator running in stop");
  a_subidle_from: assert property (
    $changed(state_r) && state_r == clock_gating_pkg::st_subidle
    |-> $past(state_r) == clock_gating_pkg::st_sub)
    else $error("subclock idle entered outside subclock mode");
  a_stab_time: assert property (
    $rose(cpu_run) && $past(state_r) == clock_gating_pkg::st_stab
    |-> $past(cnt_r) == HSI_LIM)
    else $error("execution before stabilization");
  a_reset_stop: assert property (disable iff (1'b0)
    srst |=> !cpu_system_clock && !peripheral_clock_gated && !cpu_run)
    else $error("clock running during reset");
  a_system_clock_out_enable: assert property (
    $rose(system_clock_out) |-> $past(system_clock_out_en, 2))
    else $error("clock out without software enable");
  a_deep_idle_pu: assert property (
    (state_r == clock_gating_pkg::st_deep_idle_mode)[*3] |-> !$rose(gclk[`CLK_PU]))
    else $error("ungated peripheral clock running in deep idle");
  c_halt_round: cover property (state_r == clock_gating_pkg::st_halt ##1
    state_r == clock_gating_pkg::st_run);
  c_deep_idle_mode_round: cover property (state_r == clock_gating_pkg::st_settle ##1
    state_r == clock_gating_pkg::st_run);
  c_sup_reset: cover property (supervision_reset);
  c_subidle: cover property (state_r == clock_gating_pkg::st_subidle);
endmodule : clock_gating_power_modes

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`include "clock_gating_map.svh"
module tb_top;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic halt_exec = 1'b0;
  logic wake = 1'b0;
  logic main_sel = 1'b0;
  logic pll_sel = 1'b0;
  logic subclock_source_select = 1'b0;
  logic system_clock_out_en = 1'b0;
  logic clk_mon_en = 1'b0;
  logic main_stuck = 1'b0;
  logic main_osc_clock = 1'b0;
  logic sub_osc_clock = 1'b0;
  logic pll_clock = 1'b0;
  logic low_speed_internal_clock = 1'b0;
  logic high_speed_internal_clock = 1'b0;
  clock_gating_pkg::mode_cmd_t mode_cmd = '0;
  logic cpu_run, cpu_system_clock, cpu_core_clock, peripheral_clock_gated;
  logic peripheral_clock_ungated, can_osc_clock, system_clock_out;
  logic system_clock_out_oe, supervision_reset;
  clock_gating_pkg::pm_state_t mode_state;
  clock_gating_pkg::osc_en_t osc_en;
  logic [31:0] tick = '0;
  logic [5:0] clk_v;
  logic [5:0] clk_p = '0;
  int ec[6] = '{0, 0, 0, 0, 0, 0};
  int sv_cnt = 0;
  int n_errors = 0;
  int total_checks = 0;

  clock_gating_power_modes DUT (.mclk(mclk), .srst(srst),
    .main_osc_clock(main_osc_clock), .sub_osc_clock(sub_osc_clock),
    .low_speed_internal_clock(low_speed_internal_clock),
    .high_speed_internal_clock(high_speed_internal_clock),
    .pll_clock(pll_clock), .halt_exec(halt_exec), .mode_cmd(mode_cmd),
    .wake(wake), .main_sel(main_sel), .pll_sel(pll_sel),
    .subclock_source_select(subclock_source_select),
    .system_clock_out_en(system_clock_out_en), .clk_mon_en(clk_mon_en), .cpu_run(cpu_run),
    .mode_state(mode_state), .osc_en(osc_en),
    .cpu_system_clock(cpu_system_clock), .cpu_core_clock(cpu_core_clock),
    .peripheral_clock_gated(peripheral_clock_gated),
    .peripheral_clock_ungated(peripheral_clock_ungated),
    .can_osc_clock(can_osc_clock), .system_clock_out(system_clock_out),
    .system_clock_out_oe(system_clock_out_oe),
    .supervision_reset(supervision_reset));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  // Oscillators run only while enabled; the sub oscillator never stops
  always @(posedge mclk) begin
    tick <= tick + 32'h1;
    high_speed_internal_clock <= osc_en.hsi & tick[1];
    low_speed_internal_clock <= osc_en.lsi & tick[3];
    pll_clock <= osc_en.pll & tick[0];
    sub_osc_clock <= tick[5];
    if (!main_stuck) main_osc_clock <= osc_en.main & tick[2];
  end

  // Rising edges of each gated clock: sys, core, pg, pu, can, out
  assign clk_v = {cpu_system_clock, cpu_core_clock, peripheral_clock_gated,
    peripheral_clock_ungated, can_osc_clock, system_clock_out};
  always @(posedge mclk) begin
    clk_p <= clk_v;
    for (int i = 0; i < 6; i++) if (clk_v[i] && !clk_p[i]) ec[i] <= ec[i] + 1;
    if (supervision_reset === 1'b1) sv_cnt <= sv_cnt + 1;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  task automatic chk_st(input clock_gating_pkg::pm_state_t s);
    check("mode_state", 32'(mode_state), 32'(s));
  endtask : chk_st

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic win(input int n, output logic [5:0] m, output int e);
    int s[6];
    s = ec;
    cyc(n);
    for (int i = 0; i < 6; i++) m[i] = (ec[i] != s[i]);
    e = ec[5] - s[5];
  endtask : win

  task automatic wait_st(input clock_gating_pkg::pm_state_t s, input int lim,
                         output int k);
    k = 0;
    while (mode_state !== s && k < lim) begin
      cyc(1);
      k++;
    end
    if (mode_state !== s) begin
      chk_st(s);
      end_sim();
    end
  endtask : wait_st

  task automatic req(input clock_gating_pkg::mode_req_t c);
    @(posedge mclk);
    mode_cmd <= '{wr: 1'b1, code: c};
    @(posedge mclk);
    mode_cmd <= '{wr: 1'b0, code: c};
    cyc(1);
  endtask : req

  task automatic do_halt();
    @(posedge mclk);
    halt_exec <= 1'b1;
    @(posedge mclk);
    halt_exec <= 1'b0;
    cyc(1);
  endtask : do_halt

  task automatic do_wake();
    @(posedge mclk);
    wake <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    #1;
  endtask : do_wake

  task automatic t_reset();
    logic [5:0] m;
    int e;
    int k;
    cyc(12);
    win(8, m, e);
    check("clocks in reset", m, 6'h00);
    check("oe in reset", system_clock_out_oe, 1'b0);
    @(posedge mclk);
    srst <= 1'b0;
    cyc(100);
    check("osc_en in stab", osc_en, 5'h0D);
    check("cpu_run in stab", cpu_run, 1'b0);
    k = 100;
    while (cpu_run !== 1'b1 && k < 2 * `HSI_STAB_CYC) begin
      cyc(1);
      k++;
    end
    check("stab time", k >= `HSI_STAB_CYC - 2 && k <= `HSI_STAB_CYC + 4, 1);
    if (cpu_run !== 1'b1) end_sim();
    cyc(20);
    win(256, m, e);
    check("run clocks", m, 6'h3E);
    check("sys from hsi", e >= 62 && e <= 66, 1);
    check("oe disabled", system_clock_out_oe, 1'b0);
    @(posedge mclk);
    system_clock_out_en <= 1'b1;
    main_sel <= 1'b1;
    pll_sel <= 1'b1;
    cyc(30);
    check("oe enabled", system_clock_out_oe, 1'b1);
    win(64, m, e);
    check("clock out on", m, 6'h3F);
    $display("test reset done");
  endtask : t_reset

  task automatic t_halt();
    logic [5:0] m;
    int e;
    int k;
    do_halt();
    wait_st(clock_gating_pkg::st_halt, 4, k);
    check("cpu_run halt", cpu_run, 1'b0);
    cyc(20);
    win(64, m, e);
    check("halt clocks", m, 6'h2F);
    do_wake();
    wait_st(clock_gating_pkg::st_run, 3, k);
    check("cpu_run wake", cpu_run, 1'b1);
    $display("test halt done");
  endtask : t_halt

  task automatic t_idle();
    logic [5:0] m;
    int e;
    int k;
    req(clock_gating_pkg::req_light_idle_mode);
    wait_st(clock_gating_pkg::st_light_idle_mode, 4, k);
    check("light_idle_mode pll flash", {osc_en.pll, osc_en.flash}, 2'h3);
    cyc(20);
    win(64, m, e);
    check("light_idle_mode clocks", m, 6'h04);
    do_wake();
    wait_st(clock_gating_pkg::st_run, 3, k);
    req(clock_gating_pkg::req_deep_idle_mode);
    wait_st(clock_gating_pkg::st_deep_idle_mode, 4, k);
    check("deep_idle_mode pll", osc_en.pll, 1'b0);
    check("deep_idle_mode osc", {osc_en.main, osc_en.hsi}, 2'h3);
    cyc(20);
    win(64, m, e);
    check("deep_idle_mode clocks", m, 6'h00);
    do_wake();
    wait_st(clock_gating_pkg::st_settle, 4, k);
    wait_st(clock_gating_pkg::st_run, `PLL_LOCK_CYC + 20, k);
    check("pll lock wait", k >= `PLL_LOCK_CYC - 4 && k <= `PLL_LOCK_CYC + 4, 1);
    $display("test idle done");
  endtask : t_idle

  task automatic t_stop();
    logic [5:0] m;
    int e;
    int k;
    req(clock_gating_pkg::req_stop);
    wait_st(clock_gating_pkg::st_stop, 4, k);
    check("stop osc_en", osc_en, 5'h00);
    cyc(20);
    win(64, m, e);
    check("stop clocks", m, 6'h00);
    do_wake();
    wait_st(clock_gating_pkg::st_stab, 4, k);
    wait_st(clock_gating_pkg::st_run, `HSI_STAB_CYC + 20, k);
    check("restab wait", k >= `HSI_STAB_CYC - 4, 1);
    $display("test stop done");
  endtask : t_stop

  task automatic t_sub();
    logic [5:0] m;
    int e;
    int k;
    req(clock_gating_pkg::req_subidle);
    cyc(5);
    chk_st(clock_gating_pkg::st_run);
    req(clock_gating_pkg::req_sub);
    wait_st(clock_gating_pkg::st_sub, 4, k);
    check("cpu_run sub", cpu_run, 1'b1);
    cyc(150);
    win(256, m, e);
    check("sys from subclock", e >= 3 && e <= 5, 1);
    do_halt();
    cyc(3);
    chk_st(clock_gating_pkg::st_sub);
    req(clock_gating_pkg::req_subidle);
    wait_st(clock_gating_pkg::st_subidle, 4, k);
    check("subidle pll flash", {osc_en.pll, osc_en.flash}, 2'h3);
    do_wake();
    wait_st(clock_gating_pkg::st_sub, 4, k);
    req(clock_gating_pkg::req_run);
    wait_st(clock_gating_pkg::st_run, 4, k);
    // Strap is taken during stabilization, so pass through stop
    @(posedge mclk);
    subclock_source_select <= 1'b1;
    req(clock_gating_pkg::req_stop);
    do_wake();
    wait_st(clock_gating_pkg::st_run, `HSI_STAB_CYC + 20, k);
    req(clock_gating_pkg::req_sub);
    wait_st(clock_gating_pkg::st_sub, 4, k);
    cyc(40);
    win(256, m, e);
    check("sys from low-speed osc", e >= 15 && e <= 17, 1);
    req(clock_gating_pkg::req_run);
    wait_st(clock_gating_pkg::st_run, 4, k);
    $display("test sub done");
  endtask : t_sub

  task automatic t_mon();
    int s;
    int k;
    @(posedge mclk);
    clk_mon_en <= 1'b1;
    s = sv_cnt;
    cyc(`MON_TIMEOUT_CYC + 100);
    check("no false reset", sv_cnt - s, 0);
    @(posedge mclk);
    main_stuck <= 1'b1;
    k = 0;
    while (supervision_reset !== 1'b1 && k < `MON_TIMEOUT_CYC + 20) begin
      cyc(1);
      k++;
    end
    check("supervision fired", supervision_reset, 1'b1);
    if (supervision_reset !== 1'b1) end_sim();
    check("timeout", k >= `MON_TIMEOUT_CYC - 4, 1);
    cyc(1);
    check("pulse width", supervision_reset, 1'b0);
    @(posedge mclk);
    clk_mon_en <= 1'b0;
    s = sv_cnt;
    cyc(`MON_TIMEOUT_CYC + 100);
    check("disabled monitor", sv_cnt - s, 0);
    @(posedge mclk);
    main_stuck <= 1'b0;
    $display("test supervision done");
  endtask : t_mon

  initial begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    end_sim();
  end

  initial begin
    t_reset();
    t_halt();
    t_idle();
    t_stop();
    t_sub();
    t_mon();
    end_sim();
  end
endmodule : tb_top
